// ===== hdl/pci_lock_arb_pkg.sv
// constants, register map and types for the configuration lock and bus arbiter
// assumes a 32-bit classic Wishbone slave port and a separate PCI clock domain
package pci_lock_arb_pkg;

  localparam int NUM_MASTERS = 8;
  localparam int MIDX_W = 3;
  localparam int WB_ADR_W = 10;

  // printed offsets; the low byte is the register index, byte address is index * 4
  localparam logic [31:0] OFF_PCI_STATUS = 32'hFFFF_D006;
  localparam logic [31:0] OFF_CLASS_CODE = 32'hFFFF_D008;
  localparam logic [31:0] OFF_SUB_CLASS_CODE = 32'hFFFF_D009;
  localparam logic [31:0] OFF_REVISION_ID = 32'hFFFF_D00B;
  localparam logic [31:0] OFF_SUBSYSTEM_VENDOR_ID = 32'hFFFF_D02C;
  localparam logic [31:0] OFF_SUBSYSTEM_ID = 32'hFFFF_D02E;
  localparam logic [31:0] OFF_MAX_LATENCY = 32'hFFFF_D03C;
  localparam logic [31:0] OFF_MIN_GRANT = 32'hFFFF_D03D;
  localparam logic [31:0] OFF_INTERRUPT_PIN = 32'hFFFF_D03E;
  localparam logic [7:0] IDX_PCI_STATUS = OFF_PCI_STATUS[7:0];
  localparam logic [7:0] IDX_PCI_STATUS_HI = 8'h07;
  localparam logic [7:0] IDX_CLASS_CODE = OFF_CLASS_CODE[7:0];
  localparam logic [7:0] IDX_SUB_CLASS_CODE = OFF_SUB_CLASS_CODE[7:0];
  localparam logic [7:0] IDX_REVISION_ID = OFF_REVISION_ID[7:0];
  localparam logic [7:0] IDX_SUBSYSTEM_VENDOR_ID = OFF_SUBSYSTEM_VENDOR_ID[7:0];
  localparam logic [7:0] IDX_SUBSYSTEM_ID = OFF_SUBSYSTEM_ID[7:0];
  localparam logic [7:0] IDX_MAX_LATENCY = OFF_MAX_LATENCY[7:0];
  localparam logic [7:0] IDX_MIN_GRANT = OFF_MIN_GRANT[7:0];
  localparam logic [7:0] IDX_INTERRUPT_PIN = OFF_INTERRUPT_PIN[7:0];
  localparam logic [7:0] IDX_ARB_PARKED_CTRL = 8'h40;
  localparam logic [7:0] IDX_REQ_TRACE = 8'h41;
  localparam logic [7:0] IDX_CLK_CTRL = 8'h42;
  localparam logic [7:0] IDX_CHIP_CFG = 8'h43;
  localparam logic [7:0] IDX_ARB_STATUS = 8'h44;

  // status bits 7 (fast back-to-back) and 6 (user feature) are locally writable
  localparam logic [15:0] STATUS_LOCAL_MASK = 16'h00C0;
  localparam int BMC_EN_BIT = 0;
  localparam int CFG_TIMEOUT_BIT = 14;
  localparam int CFG_INT_CLK_BIT = 0;

  // reset values; identity bytes are arbitrary neutral values
  localparam logic [15:0] PCI_STATUS_RST = 16'h0000;
  localparam logic [7:0] ID_BYTE_RST = 8'h00;
  localparam logic [15:0] ID_WORD_RST = 16'h0000;
  localparam logic [7:0] REQ_TRACE_RST = 8'hF0;
  localparam logic [MIDX_W-1:0] PARK_RST = 3'h4;
  localparam logic [3:0] CLK_EN_RST = 4'h1;

  // upper group slots: masters 0..7 plus slot 8 standing for the lower group
  localparam logic [3:0] LOWER_SLOT = 4'h8;
  localparam logic [3:0] UPPER_SLOTS = 4'h9;
  localparam logic [4:0] BROKEN_LIMIT = 5'h10;
  localparam logic [1:0] PCLK_DIV_LAST = 2'h3;

  typedef enum logic [1:0] {ARB_IDLE, ARB_WAIT, ARB_OWNED} arb_state_t;

endpackage

// ===== hdl/pci_lock_arb.sv
// configuration write lock, two-level arbiter and PCI clock outputs
// clk_i carries the Wishbone side and PCI clock outputs; pci_clk_i carries the other PCI pins and arbiter
// request/frame pins are synchronised on pci_clk_i before use
`timescale 1ns/1ps
module pci_lock_arb (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [pci_lock_arb_pkg::WB_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic pci_clk_i,
  input wire logic ext_cfg_wr_i,
  input wire logic [7:0] ext_cfg_addr_i,
  input wire logic [7:0] ext_cfg_data_i,
  output logic ext_cfg_ready_o,
  input wire logic [pci_lock_arb_pkg::NUM_MASTERS-1:0] req_n_i,
  output logic [pci_lock_arb_pkg::NUM_MASTERS-1:0] gnt_n_o,
  input wire logic frame_n_i,
  input wire logic irdy_n_i,
  output logic [3:0] pci_clock_output_o,
  output logic [3:0] pci_clock_output_oe_o,
  output logic bus_timeout_enable_o
);
  import pci_lock_arb_pkg::*;

  typedef struct packed {
    logic wb_ack;
    logic [31:0] wb_rdata;
    logic [15:0] pci_status;
    logic [7:0] class_code;
    logic [7:0] sub_class_code;
    logic [7:0] revision_id;
    logic [15:0] subsystem_vendor_id;
    logic [15:0] subsystem_id;
    logic [7:0] max_latency;
    logic [7:0] min_grant;
    logic [7:0] interrupt_pin;
    logic bmc_en;
    logic [7:0] req_trace;
    logic [3:0] clk_en;
    logic int_clk;
    logic timeout_en;
    logic sent_bmc;
    logic [7:0] sent_trace;
    logic cfg_tog;
    logic cfg_ack_s1;
    logic cfg_ack_s2;
    logic ext_s1;
    logic ext_s2;
    logic ext_ack;
    logic stat_s1;
    logic stat_s2;
    logic stat_ack;
    logic [15:0] arb_view;
    logic [1:0] div_cnt;
    logic pclk;
  } sys_state_t;

  typedef struct packed {
    logic [NUM_MASTERS-1:0] req_s1;
    logic [NUM_MASTERS-1:0] req_s2;
    logic frame_s1;
    logic frame_s2;
    logic irdy_s1;
    logic irdy_s2;
    logic cfg_s1;
    logic cfg_s2;
    logic cfg_ack;
    logic bmc_en;
    logic [7:0] trace;
    logic ext_tog;
    logic ext_ack_s1;
    logic ext_ack_s2;
    logic [7:0] ext_addr;
    logic [7:0] ext_data;
    logic stat_tog;
    logic stat_ack_s1;
    logic stat_ack_s2;
    logic [15:0] stat_hold;
    arb_state_t state;
    logic [MIDX_W-1:0] owner;
    logic [3:0] upper_last;
    logic [MIDX_W-1:0] park;
    logic [4:0] wait_cnt;
    logic [NUM_MASTERS-1:0] broken;
  } pci_state_t;

  sys_state_t s_reg, s_next;
  pci_state_t p_reg, p_next;
  logic prst_s1, prst_s2;

  // upper group round robin; slot 8 is the lower group as one participant
  function automatic logic [3:0] pick_upper(input logic [8:0] want, input logic [3:0] last);
    logic [3:0] slot;
    logic [3:0] win;
    win = last;
    for (int k = 9; k >= 1; k--) begin
      slot = 4'((int'(last) + k) % int'(UPPER_SLOTS));
      if (want[slot]) begin
        win = slot;
      end
    end
    return win;
  endfunction

  // lower group: parked master first, then in turn after it
  function automatic logic [MIDX_W-1:0] pick_lower(input logic [7:0] want,
                                                    input logic [MIDX_W-1:0] park);
    logic [MIDX_W-1:0] idx;
    logic [MIDX_W-1:0] win;
    win = park;
    for (int k = 7; k >= 0; k--) begin
      idx = park + MIDX_W'(k);
      if (want[idx]) begin
        win = idx;
      end
    end
    return win;
  endfunction

  // system side: bus slave, locked configuration bytes, crossings, clock divider
  always_comb begin
    logic acc;
    logic wr;
    logic [7:0] idx;
    logic [7:0] lo_mask;
    logic [7:0] hi_mask;
    acc = 1'b0;
    wr = 1'b0;
    idx = 8'h00;
    lo_mask = STATUS_LOCAL_MASK[7:0];
    hi_mask = STATUS_LOCAL_MASK[15:8];
    s_next = s_reg;
    s_next.cfg_ack_s1 = p_reg.cfg_ack;
    s_next.cfg_ack_s2 = s_reg.cfg_ack_s1;
    s_next.ext_s1 = p_reg.ext_tog;
    s_next.ext_s2 = s_reg.ext_s1;
    s_next.stat_s1 = p_reg.stat_tog;
    s_next.stat_s2 = s_reg.stat_s1;
    acc = wb_cyc_i & wb_stb_i & ~s_reg.wb_ack;
    wr = acc & wb_we_i;
    idx = wb_adr_i[WB_ADR_W-1:2];
    s_next.wb_ack = acc;
    // external write first: only unlocked status bits may change
    if (s_reg.ext_s2 != s_reg.ext_ack) begin
      s_next.ext_ack = s_reg.ext_s2;
      unique case (p_reg.ext_addr)
        IDX_PCI_STATUS: s_next.pci_status[7:0] =
          (s_reg.pci_status[7:0] & lo_mask) | (p_reg.ext_data & ~lo_mask);
        IDX_PCI_STATUS_HI: s_next.pci_status[15:8] =
          (s_reg.pci_status[15:8] & hi_mask) | (p_reg.ext_data & ~hi_mask);
        default: ; // identity, latency and pin bytes ignore external data
      endcase
    end
    // local CPU write comes last so it wins a same-cycle collision
    if (wr) begin
      unique case (idx)
        IDX_PCI_STATUS: begin
          if (wb_sel_i[0]) s_next.pci_status[7:0] = wb_dat_i[7:0];
          if (wb_sel_i[1]) s_next.pci_status[15:8] = wb_dat_i[15:8];
        end
        IDX_CLASS_CODE: if (wb_sel_i[0]) s_next.class_code = wb_dat_i[7:0];
        IDX_SUB_CLASS_CODE: if (wb_sel_i[0]) s_next.sub_class_code = wb_dat_i[7:0];
        IDX_REVISION_ID: if (wb_sel_i[0]) s_next.revision_id = wb_dat_i[7:0];
        IDX_SUBSYSTEM_VENDOR_ID: begin
          if (wb_sel_i[0]) s_next.subsystem_vendor_id[7:0] = wb_dat_i[7:0];
          if (wb_sel_i[1]) s_next.subsystem_vendor_id[15:8] = wb_dat_i[15:8];
        end
        IDX_SUBSYSTEM_ID: begin
          if (wb_sel_i[0]) s_next.subsystem_id[7:0] = wb_dat_i[7:0];
          if (wb_sel_i[1]) s_next.subsystem_id[15:8] = wb_dat_i[15:8];
        end
        IDX_MAX_LATENCY: if (wb_sel_i[0]) s_next.max_latency = wb_dat_i[7:0];
        IDX_MIN_GRANT: if (wb_sel_i[0]) s_next.min_grant = wb_dat_i[7:0];
        IDX_INTERRUPT_PIN: if (wb_sel_i[0]) s_next.interrupt_pin = wb_dat_i[7:0];
        IDX_ARB_PARKED_CTRL: if (wb_sel_i[0]) s_next.bmc_en = wb_dat_i[BMC_EN_BIT];
        IDX_REQ_TRACE: if (wb_sel_i[0]) s_next.req_trace = wb_dat_i[7:0];
        IDX_CLK_CTRL: if (wb_sel_i[0]) s_next.clk_en = wb_dat_i[3:0];
        IDX_CHIP_CFG: begin
          if (wb_sel_i[0]) s_next.int_clk = wb_dat_i[CFG_INT_CLK_BIT];
          if (wb_sel_i[1]) s_next.timeout_en = wb_dat_i[CFG_TIMEOUT_BIT];
        end
        default: ;
      endcase
    end
    // read data registered with the ack; unmapped indices read zero
    if (acc) begin
      s_next.wb_rdata = 32'h0000_0000;
      unique case (idx)
        IDX_PCI_STATUS: s_next.wb_rdata[15:0] = s_reg.pci_status;
        IDX_CLASS_CODE: s_next.wb_rdata[7:0] = s_reg.class_code;
        IDX_SUB_CLASS_CODE: s_next.wb_rdata[7:0] = s_reg.sub_class_code;
        IDX_REVISION_ID: s_next.wb_rdata[7:0] = s_reg.revision_id;
        IDX_SUBSYSTEM_VENDOR_ID: s_next.wb_rdata[15:0] = s_reg.subsystem_vendor_id;
        IDX_SUBSYSTEM_ID: s_next.wb_rdata[15:0] = s_reg.subsystem_id;
        IDX_MAX_LATENCY: s_next.wb_rdata[7:0] = s_reg.max_latency;
        IDX_MIN_GRANT: s_next.wb_rdata[7:0] = s_reg.min_grant;
        IDX_INTERRUPT_PIN: s_next.wb_rdata[7:0] = s_reg.interrupt_pin;
        IDX_ARB_PARKED_CTRL: s_next.wb_rdata[BMC_EN_BIT] = s_reg.bmc_en;
        IDX_REQ_TRACE: s_next.wb_rdata[7:0] = s_reg.req_trace;
        IDX_CLK_CTRL: s_next.wb_rdata[3:0] = s_reg.clk_en;
        IDX_CHIP_CFG: begin
          s_next.wb_rdata[CFG_INT_CLK_BIT] = s_reg.int_clk;
          s_next.wb_rdata[CFG_TIMEOUT_BIT] = s_reg.timeout_en;
        end
        IDX_ARB_STATUS: s_next.wb_rdata[15:0] = s_reg.arb_view;
        default: ;
      endcase
    end
    // arbiter settings go across one word at a time, held until acknowledged
    if (s_reg.cfg_tog == s_reg.cfg_ack_s2 &&
        (s_reg.sent_bmc != s_reg.bmc_en || s_reg.sent_trace != s_reg.req_trace)) begin
      s_next.sent_bmc = s_reg.bmc_en;
      s_next.sent_trace = s_reg.req_trace;
      s_next.cfg_tog = ~s_reg.cfg_tog;
    end
    // arbiter state view arrives by handshake
    if (s_reg.stat_s2 != s_reg.stat_ack) begin
      s_next.stat_ack = s_reg.stat_s2;
      s_next.arb_view = p_reg.stat_hold;
    end
    // internally generated PCI clock: clk_i divided by eight
    s_next.div_cnt = s_reg.div_cnt + 2'h1;
    if (s_reg.div_cnt == PCLK_DIV_LAST) begin
      s_next.div_cnt = 2'h0;
      s_next.pclk = ~s_reg.pclk;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= '0;
      s_reg.pci_status <= PCI_STATUS_RST;
      s_reg.class_code <= ID_BYTE_RST;
      s_reg.sub_class_code <= ID_BYTE_RST;
      s_reg.revision_id <= ID_BYTE_RST;
      s_reg.subsystem_vendor_id <= ID_WORD_RST;
      s_reg.subsystem_id <= ID_WORD_RST;
      s_reg.req_trace <= REQ_TRACE_RST;
      s_reg.sent_trace <= REQ_TRACE_RST;
      s_reg.clk_en <= CLK_EN_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // reset reaches the PCI domain through two flops
  always_ff @(posedge pci_clk_i) begin
    prst_s1 <= rst_i;
    prst_s2 <= prst_s1;
  end

  // PCI side: external write capture, settings intake, two-level arbiter
  always_comb begin
    logic [NUM_MASTERS-1:0] req;
    logic [NUM_MASTERS-1:0] low_req;
    logic [8:0] up_want;
    logic [3:0] slot;
    logic [MIDX_W-1:0] win;
    logic bus_idle;
    logic owner_req;
    req = '0;
    low_req = '0;
    up_want = '0;
    slot = 4'h0;
    win = '0;
    p_next = p_reg;
    p_next.req_s1 = req_n_i;
    p_next.req_s2 = p_reg.req_s1;
    p_next.frame_s1 = frame_n_i;
    p_next.frame_s2 = p_reg.frame_s1;
    p_next.irdy_s1 = irdy_n_i;
    p_next.irdy_s2 = p_reg.irdy_s1;
    p_next.cfg_s1 = s_reg.cfg_tog;
    p_next.cfg_s2 = p_reg.cfg_s1;
    p_next.ext_ack_s1 = s_reg.ext_ack;
    p_next.ext_ack_s2 = p_reg.ext_ack_s1;
    p_next.stat_ack_s1 = s_reg.stat_ack;
    p_next.stat_ack_s2 = p_reg.stat_ack_s1;
    bus_idle = p_reg.frame_s2 & p_reg.irdy_s2;
    // external configuration write: one byte in flight, refused while busy
    if (ext_cfg_wr_i && p_reg.ext_tog == p_reg.ext_ack_s2) begin
      p_next.ext_addr = ext_cfg_addr_i;
      p_next.ext_data = ext_cfg_data_i;
      p_next.ext_tog = ~p_reg.ext_tog;
    end
    if (p_reg.cfg_s2 != p_reg.cfg_ack) begin
      p_next.cfg_ack = p_reg.cfg_s2;
      p_next.bmc_en = s_reg.sent_bmc;
      p_next.trace = s_reg.sent_trace;
    end
    if (!p_reg.bmc_en) begin
      p_next.broken = '0;
    end
    req = ~p_reg.req_s2 & ~p_reg.broken;
    low_req = req & p_reg.trace;
    up_want = {|low_req, req & ~p_reg.trace};
    owner_req = req[p_reg.owner];
    unique case (p_reg.state)
      ARB_IDLE: begin
        if (|up_want) begin
          slot = pick_upper(up_want, p_reg.upper_last);
          p_next.upper_last = slot;
          if (slot == LOWER_SLOT) begin
            win = pick_lower(low_req, p_reg.park);
            p_next.park = win;
          end else begin
            win = slot[MIDX_W-1:0];
          end
          p_next.owner = win;
          p_next.wait_cnt = 5'h00;
          p_next.state = ARB_WAIT;
        end
      end
      ARB_WAIT: begin
        p_next.wait_cnt = p_reg.wait_cnt + 5'h01;
        if (!p_reg.frame_s2) begin
          p_next.state = ARB_OWNED;
        end else if (!owner_req) begin
          p_next.state = ARB_IDLE;
        end else if (p_reg.bmc_en && p_reg.wait_cnt == BROKEN_LIMIT - 5'h01) begin
          p_next.broken[p_reg.owner] = 1'b1;
          p_next.state = ARB_IDLE;
        end
      end
      ARB_OWNED: begin
        // the broken count never runs here, so a working master is never cut
        if (!owner_req && bus_idle) begin
          p_next.state = ARB_IDLE;
        end
      end
    endcase
    // report owner, park and broken set to the system side when idle to do so
    if (p_reg.stat_tog == p_reg.stat_ack_s2) begin
      p_next.stat_hold = {p_reg.state != ARB_IDLE, p_reg.owner, 1'b0, p_reg.park,
                          p_reg.broken};
      if (p_next.stat_hold != p_reg.stat_hold) begin
        p_next.stat_tog = ~p_reg.stat_tog;
      end
    end
  end

  always_ff @(posedge pci_clk_i) begin
    if (prst_s2) begin
      p_reg <= '0;
      p_reg.req_s1 <= '1;
      p_reg.req_s2 <= '1;
      p_reg.frame_s1 <= 1'b1;
      p_reg.frame_s2 <= 1'b1;
      p_reg.irdy_s1 <= 1'b1;
      p_reg.irdy_s2 <= 1'b1;
      p_reg.trace <= REQ_TRACE_RST;
      p_reg.park <= PARK_RST;
      p_reg.upper_last <= LOWER_SLOT;
      p_reg.state <= ARB_IDLE;
    end else begin
      p_reg <= p_next;
    end
  end

  // one-hot low grant straight from the owner register
  for (genvar g = 0; g < NUM_MASTERS; g++) begin : g_gnt
    assign gnt_n_o[g] = ~(p_reg.state != ARB_IDLE && p_reg.owner == MIDX_W'(g));
  end

  assign wb_ack_o = s_reg.wb_ack;
  assign wb_dat_o = s_reg.wb_rdata;
  assign ext_cfg_ready_o = (p_reg.ext_tog == p_reg.ext_ack_s2);
  assign pci_clock_output_o = {4{s_reg.pclk}};
  // output 0 is forced on while the internal clock is selected
  assign pci_clock_output_oe_o = s_reg.clk_en | {3'b000, s_reg.int_clk};
  assign bus_timeout_enable_o = s_reg.timeout_en;

endmodule

// ===== bench/pci_lock_arb_monitor.sv
// port checker for the configuration lock and two-level arbiter
// assumes it is bound into pci_lock_arb; rst_i also quiets pci-side checks
`timescale 1ns/1ps
module pci_lock_arb_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic pci_clk_i,
  input wire logic ext_cfg_wr_i,
  input wire logic ext_cfg_ready_o,
  input wire logic [pci_lock_arb_pkg::NUM_MASTERS-1:0] req_n_i,
  input wire logic [pci_lock_arb_pkg::NUM_MASTERS-1:0] gnt_n_o,
  input wire logic frame_n_i,
  input wire logic irdy_n_i,
  input wire logic [3:0] pci_clock_output_oe_o,
  input wire logic bus_timeout_enable_o
);
  import pci_lock_arb_pkg::*;
  // a request the slave has not answered yet
  sequence s_wb_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  a_ack_next: assert property (@(posedge clk_i) disable iff (rst_i)
    s_wb_req |=> wb_ack_o) else $error("ack missing after request");
  a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  a_reset_state: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(rst_i) |-> pci_clock_output_oe_o == 4'h1 && !bus_timeout_enable_o && &gnt_n_o)
    else $error("wrong state after reset");
  a_ready_drops: assert property (@(posedge pci_clk_i) disable iff (rst_i)
    ext_cfg_wr_i && ext_cfg_ready_o |=> !ext_cfg_ready_o) else $error("ready kept after write");
  a_one_grant: assert property (@(posedge pci_clk_i) disable iff (rst_i)
    $onehot0(~gnt_n_o)) else $error("more than one grant");
  a_grant_has_req: assert property (@(posedge pci_clk_i) disable iff (rst_i)
    (~gnt_n_o & $past(gnt_n_o) & $past(req_n_i, 3)) == '0) else $error("grant without request");
  a_no_direct_switch: assert property (@(posedge pci_clk_i) disable iff (rst_i)
    !(&$past(gnt_n_o)) && !(&gnt_n_o) |-> gnt_n_o == $past(gnt_n_o))
    else $error("grant moved without idle gap");
  // owner idle for three cycles: grant must go soon after
  for (genvar k = 0; k < NUM_MASTERS; k++) begin : g_rel
    sequence s_released;
      (!gnt_n_o[k] && req_n_i[k] && frame_n_i && irdy_n_i) ##1
        (req_n_i[k] && frame_n_i && irdy_n_i) [*2];
    endsequence
    a_grant_release: assert property (@(posedge pci_clk_i) disable iff (rst_i)
      s_released |-> ##[1:3] gnt_n_o[k]) else $error("grant kept after release");
  end
endmodule
bind pci_lock_arb pci_lock_arb_monitor i_mon (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .pci_clk_i(pci_clk_i), .ext_cfg_wr_i(ext_cfg_wr_i),
  .ext_cfg_ready_o(ext_cfg_ready_o), .req_n_i(req_n_i), .gnt_n_o(gnt_n_o),
  .frame_n_i(frame_n_i), .irdy_n_i(irdy_n_i), .pci_clock_output_oe_o(pci_clock_output_oe_o),
  .bus_timeout_enable_o(bus_timeout_enable_o)
);

// ===== bench/pci_master_model.sv
// behavioural pci masters plus an external configuration byte writer
// assumes pull-ups on req, frame and irdy, so released lines read high
`timescale 1ns/1ps
module pci_master_model (
  input wire logic pci_clk_i,
  input wire logic [7:0] gnt_n_i,
  input wire logic ext_cfg_ready_i,
  output logic [7:0] req_n_o,
  output logic frame_n_o,
  output logic irdy_n_o,
  output logic ext_cfg_wr_o,
  output logic [7:0] ext_cfg_addr_o,
  output logic [7:0] ext_cfg_data_o
);
  initial begin
    req_n_o = 8'hFF;
    frame_n_o = 1'b1;
    irdy_n_o = 1'b1;
    ext_cfg_wr_o = 1'b0;
    ext_cfg_addr_o = 8'h00;
    ext_cfg_data_o = 8'h00;
  end
  // request; a granted owner runs a short frame when frm is set, otherwise holds req asserted for hold cycles
  task automatic request(input int k, input bit frm, input int hold, input int max_wait,
      output bit got, output int waited);
    got = 1'b0;
    waited = 0;
    @(posedge pci_clk_i);
    req_n_o[k] <= 1'b0;
    while (!got && waited < max_wait) begin
      @(negedge pci_clk_i);
      waited++;
      got = (gnt_n_i[k] === 1'b0);
    end
    if (got && frm) begin
      @(posedge pci_clk_i);
      frame_n_o <= 1'b0;
      irdy_n_o <= 1'b0;
      @(posedge pci_clk_i);
      frame_n_o <= 1'b1;
      @(posedge pci_clk_i);
      irdy_n_o <= 1'b1;
    end else begin
      repeat (hold) @(posedge pci_clk_i);
    end
    @(posedge pci_clk_i);
    req_n_o[k] <= 1'b1;
    repeat (5) @(posedge pci_clk_i);
  endtask
  // one byte; waits for ready both before and after, a lost write would hide faults
  task automatic cfg_write(input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(negedge pci_clk_i);
    while (ext_cfg_ready_i !== 1'b1 && n < 64) begin
      @(negedge pci_clk_i);
      n++;
    end
    @(posedge pci_clk_i);
    ext_cfg_wr_o <= 1'b1;
    ext_cfg_addr_o <= a;
    ext_cfg_data_o <= d;
    @(posedge pci_clk_i);
    ext_cfg_wr_o <= 1'b0;
    ext_cfg_addr_o <= ~a;
    ext_cfg_data_o <= ~d;
    n = 0;
    @(negedge pci_clk_i);
    while (ext_cfg_ready_i !== 1'b1 && n < 64) begin
      @(negedge pci_clk_i);
      n++;
    end
  endtask
endmodule

// ===== bench/pci_lock_arb_tb.sv
// self-checking bench: wishbone tasks, partner masters, register scoreboard
// assumes a free running pci clock of 48 ns unrelated to the 4 ns clock
`timescale 1ns/1ps
module pci_lock_arb_tb;
  import pci_lock_arb_pkg::*;
  logic clk_i = 1'b0;
  logic pci_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [WB_ADR_W-1:0] wb_adr_i = '0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, cfg_wr, cfg_rdy, frame_n, irdy_n, tmo_en;
  logic [7:0] cfg_a, cfg_d;
  logic [NUM_MASTERS-1:0] req_n, gnt_n;
  logic [3:0] clk_out, clk_oe;
  int bad_count = 0;
  int num_checks = 0;
  int cycles = 0;
  logic [31:0] mdl [256];
  logic [7:0] idx_list [14] = '{8'h06, 8'h08, 8'h09, 8'h0B, 8'h2C, 8'h2E, 8'h3C, 8'h3D,
    8'h3E, 8'h40, 8'h41, 8'h42, 8'h43, 8'h50};
  always #2 clk_i = ~clk_i;
  // odd start offset keeps the two clocks out of step
  initial begin
    #1.3;
    forever #24 pci_clk_i = ~pci_clk_i;
  end
  pci_lock_arb i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pci_clk_i(pci_clk_i), .ext_cfg_wr_i(cfg_wr),
    .ext_cfg_addr_i(cfg_a), .ext_cfg_data_i(cfg_d), .ext_cfg_ready_o(cfg_rdy),
    .req_n_i(req_n), .gnt_n_o(gnt_n), .frame_n_i(frame_n), .irdy_n_i(irdy_n),
    .pci_clock_output_o(clk_out), .pci_clock_output_oe_o(clk_oe),
    .bus_timeout_enable_o(tmo_en));
  pci_master_model m (.pci_clk_i(pci_clk_i), .gnt_n_i(gnt_n), .ext_cfg_ready_i(cfg_rdy),
    .req_n_o(req_n), .frame_n_o(frame_n), .irdy_n_o(irdy_n), .ext_cfg_wr_o(cfg_wr),
    .ext_cfg_addr_o(cfg_a), .ext_cfg_data_o(cfg_d));
  task automatic results();
    if (bad_count == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // stored width of each register; unmapped place reads whole zero
  function automatic logic [31:0] wmask(input logic [7:0] idx);
    case (idx)
      8'h06, 8'h2C, 8'h2E: return 32'h0000FFFF;
      8'h40: return 32'h00000001;
      8'h42: return 32'h0000000F;
      8'h43: return 32'h00004001;
      8'h50: return 32'hFFFFFFFF;
      default: return 32'h000000FF;
    endcase
  endfunction
  // classic single cycle; data taken at the edge that sees ack
  task automatic wb(input logic we, input logic [7:0] idx, input logic [31:0] d,
      output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_sel_i <= 4'hF;
    wb_dat_i <= d;
    @(negedge clk_i);
    while (wb_ack_o !== 1'b1 && n < 32) begin
      @(negedge clk_i);
      n++;
    end
    if (n == 32) chk("wb ack", 32'h1, 32'h0);
    @(posedge clk_i);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_dat_i <= ~d;
  endtask
  task automatic lwr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, idx, d, q);
    mdl[idx] = d & wmask(idx);
  endtask
  task automatic rd_all();
    logic [31:0] q;
    foreach (idx_list[i]) begin
      wb(1'b0, idx_list[i], 32'h0, q);
      chk($sformatf("reg %h", idx_list[i]), mdl[idx_list[i]], q & wmask(idx_list[i]));
    end
  endtask
  // only status bits outside the local mask take external data
  task automatic ext_wr(input logic [7:0] a, input logic [7:0] d);
    m.cfg_write(a, d);
    if (a == 8'h06) mdl[6][7:0] = (mdl[6][7:0] & 8'hC0) | (d & 8'h3F);
    if (a == 8'h07) mdl[6][15:8] = d;
    repeat (8) @(posedge clk_i);
  endtask
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      bad_count++;
      results();
    end
  end
  initial begin
    logic [31:0] q;
    bit g1, g2;
    int w1, w2;
    foreach (mdl[i]) mdl[i] = 32'h0;
    mdl[8'h41] = 32'hF0;
    mdl[8'h42] = 32'h1;
    void'($urandom(43296));
    repeat (20) @(posedge clk_i);
    repeat (4) @(posedge pci_clk_i);
    @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge pci_clk_i);
    rd_all();
    wb(1'b0, 8'h44, 32'h0, q);
    chk("parked", 32'h4, {29'h0, q[10:8]});
    // local writes stick; inverted external bytes land only on unlocked status bits
    for (int i = 0; i < 9; i++) begin
      lwr(idx_list[i], $urandom);
      ext_wr(idx_list[i], ~mdl[idx_list[i]][7:0]);
    end
    rd_all();
    ext_wr(8'h07, 8'($urandom));
    ext_wr(8'h06, mdl[6][7:0]);
    wb(1'b1, 8'h50, $urandom, q);
    // external writes racing cpu Wishbone writes to other registers
    fork
      begin
        ext_wr(8'h08, 8'hA5);
        ext_wr(8'h06, 8'hFF);
      end
      repeat (30) begin
        lwr(8'h09, $urandom);
        lwr(8'h42, 32'h0000000F);
      end
    join
    rd_all();
    lwr(8'h42, 32'h0);
    lwr(8'h43, 32'h0);
    repeat (6) @(posedge pci_clk_i);
    chk("clock oe", 32'h0, {28'h0, clk_oe});
    lwr(8'h43, 32'h4001);
    lwr(8'h42, 32'hA);
    repeat (6) @(posedge pci_clk_i);
    chk("clock oe", 32'hB, {28'h0, clk_oe});
    chk("timeout enable", 32'h1, {31'h0, tmo_en});
    // four posedges between two negedges hold exactly one divider toggle
    @(negedge clk_i);
    q = {28'h0, clk_out};
    repeat (4) @(negedge clk_i);
    chk("clock out", {28'h0, {4{~q[0]}}}, {28'h0, clk_out});
    for (int k = 0; k < 4; k++) begin
      m.request(k, 1'b1, 0, 20, g1, w1);
      chk("upper grant", 32'h1, {31'h0, g1});
    end
    m.request(6, 1'b1, 0, 20, g1, w1);
    wb(1'b0, 8'h44, 32'h0, q);
    chk("parked", 32'h6, {29'h0, q[10:8]});
    // parked 6 idle: ascending wrap serves 7 before 4
    fork
      m.request(4, 1'b1, 0, 40, g1, w1);
      m.request(7, 1'b1, 0, 40, g2, w2);
    join
    chk("lower order", 32'h1, {31'h0, g1 && g2 && (w2 < w1)});
    lwr(8'h41, 32'h0);
    m.request(5, 1'b1, 0, 20, g1, w1);
    wb(1'b0, 8'h44, 32'h0, q);
    chk("trace upper", 32'h14, {27'h0, g1, 1'b0, q[10:8]});
    lwr(8'h41, 32'hF0);
    // upper master stalls without frame while parked lower master asks
    lwr(8'h40, 32'h1);
    fork
      m.request(1, 1'b0, 40, 20, g1, w1);
      begin
        repeat (6) @(posedge pci_clk_i);
        m.request(4, 1'b1, 0, 60, g2, w2);
      end
    join
    wb(1'b0, 8'h44, 32'h0, q);
    chk("broken set", 32'h102, {23'h0, g2, q[7:0]});
    m.request(1, 1'b1, 0, 12, g1, w1);
    chk("broken refused", 32'h0, {31'h0, g1});
    lwr(8'h40, 32'h0);
    repeat (6) @(posedge pci_clk_i);
    wb(1'b0, 8'h44, 32'h0, q);
    chk("broken cleared", 32'h0, {24'h0, q[7:0]});
    rd_all();
    results();
  end
endmodule
